/* File: verilog/ctdc_pkg.sv */
// Constants, types and register map of the CAN transceiver digital control block
package ctdc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] OFS_PORT_LINE_DATA = 3'h0;
    localparam logic [2:0] OFS_TRANSCEIVER_CONTROL = 3'h1;
    localparam logic [2:0] OFS_FACTORY_TEST_A = 3'h2;
    localparam logic [2:0] OFS_LINE_MONITOR_STATUS = 3'h3;
    localparam logic [2:0] OFS_FACTORY_TEST_B = 3'h4;
    localparam logic [2:0] OFS_FACTORY_TEST_C = 3'h5;
    localparam logic [2:0] OFS_FAULT_IRQ_ENABLE = 3'h6;
    localparam logic [2:0] OFS_FAULT_IRQ_FLAGS = 3'h7;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_WAKE_RX_SAMPLE = 7;
    localparam int BIT_TX_LINE_OVERRIDE = 1;
    localparam int BIT_RX_LINE_SAMPLE = 0;
    localparam int BIT_TRANSCEIVER_ENABLE = 7;
    localparam int BIT_MIDPOINT_BIAS_ENABLE = 6;
    localparam int POS_WAKE_FILTER_SELECT = 4;
    localparam int POS_SLEW_RATE_SELECT = 0;
    localparam int BIT_TX_DOMINANT_TIMEOUT = 3;
    localparam int POS_VOLTAGE_MONITOR = 4;
    localparam logic [7:0] IRQ_ENABLE_MASK = 8'h19;
    localparam logic [7:0] IRQ_FLAGS_MASK = 8'hFB;

    // ****************************************
    // Codes and values after reset
    // ****************************************
    localparam logic [2:0] SLEW_RSVD_A = 3'h3;
    localparam logic [2:0] SLEW_RSVD_B = 3'h7;
    localparam logic [1:0] WAKE_OFF = 2'h0;
    localparam logic [1:0] WAKE_MASK_ONE = 2'h1;
    localparam logic [1:0] WAKE_MASK_TWO = 2'h3;
    localparam logic RST_TX_LINE_OVERRIDE = 1'b1;
    localparam logic [1:0] RST_WAKE_FILTER_SELECT = 2'h2;
    localparam logic [2:0] RST_SLEW_RATE_SELECT = 3'h0;
    localparam logic [7:0] RST_FACTORY_TEST = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS = 40;
    localparam int RECESSIVE_CLEAR_NS = 1000;
    localparam int TIMEOUT_NS = 500000;
    // Longer than 1 us: round up, then one more cycle to exceed it
    localparam int RECESSIVE_CLEAR_CYC = (RECESSIVE_CLEAR_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int TIMEOUT_CYC_DEF = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        CTDC_SHUTDOWN,
        CTDC_NORMAL,
        CTDC_STANDBY
    } ctdc_mode_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wrData;
        logic wr;
        logic rd;
    } ctdc_bus_req_s;

endpackage : ctdc_pkg

/* File: verilog/ctdc_sync2.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain
module ctdc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic clock,
    input wire logic rstSync_n,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import ctdc_pkg::*;

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_r;

    // ****************************************
    // Synchroniser stages
    // ****************************************
    // First stage feeds only the second; reset value is each line's idle level
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            meta_r <= RST_VAL;
            syncOut <= RST_VAL;
        end else if (clkEn) begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule : ctdc_sync2

/* File: verilog/ctdc_top.sv */
// CAN transceiver digital control: routing, mode, wake filter, registers
//
// Local design decision: strobed register access.
module ctdc_top #(
    parameter int TIMEOUT_CYC = ctdc_pkg::TIMEOUT_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire ctdc_pkg::ctdc_bus_req_s regReq,
    output logic [7:0] regRdData,
    input wire logic controllerTxOut,
    input wire logic txRouteToReg,
    input wire logic rxRouteAlt,
    input wire logic specialMode,
    input wire logic cpuStopReq,
    input wire logic regulatorReducedPerformance,
    input wire logic precisionRxLevel,
    input wire logic wakeRxLevel,
    input wire logic [3:0] voltageMonitor,
    input wire logic [1:0] overCurrentMonitor,
    output logic txLineIn,
    output logic rxLineOut,
    output logic controllerRxIn,
    output ctdc_pkg::ctdc_mode_e transceiverMode,
    output logic midpointBiasDrive,
    output logic wakeRxEnable,
    output logic [2:0] slewRateSelect
);
    import ctdc_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 65535) begin : g_bad_timeout
        $error("TIMEOUT_CYC must lie in 2..65535");
    end

    localparam logic [15:0] TO_LAST = 16'(TIMEOUT_CYC - 1);
    localparam logic [15:0] REC_LAST = 16'(RECESSIVE_CLEAR_CYC - 1);
    localparam logic [15:0] TO_CAP = 16'(TIMEOUT_CYC);

    logic rstMeta_r;
    logic rstSync;
    logic precSync;
    logic wakeSync;
    logic rpmSync;
    logic [3:0] vfSync;
    logic [1:0] ocSync;
    logic txOverride_r;
    logic enable_r;
    logic bias_r;
    logic [1:0] wakeSel_r;
    logic [7:0] factory_r [3];
    logic [7:0] irqEnable_r;
    logic [7:0] irqFlags_r;
    logic [7:0] irqSet;
    logic [7:0] irqClr;
    logic [15:0] domCnt_r;
    logic [15:0] recCnt_r;
    logic timeout_r;
    logic dtEvent;
    logic [3:0] vfPrev_r;
    logic [1:0] ocPrev_r;
    logic wakePrev_r;
    logic stopPrev_r;
    logic [1:0] maskCnt_r;
    logic suppress_r;
    logic maskHit;
    logic wakeFell;
    logic rxNxt;
    ctdc_mode_e modeNxt;
    logic [7:0] rdValue;
    logic wrPort;
    logic wrCtrl;
    logic wrIrqEn;
    logic wrFlags;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstSync);

    // ****************************************
    // Reset release and input synchronisers
    // ****************************************
    // Reset asserts at once, releases after two edges
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync <= rstMeta_r;
        end
    end

    // Receivers idle recessive, monitors idle clear: no false flag after reset
    ctdc_sync2 #(
        .WIDTH(9),
        .RST_VAL(9'h180)
    ) u_sync (
        .clock(clock),
        .rstSync_n(rstSync),
        .clkEn(clkEn),
        .asyncIn({precisionRxLevel, wakeRxLevel, regulatorReducedPerformance,
                  voltageMonitor, overCurrentMonitor}),
        .syncOut({precSync, wakeSync, rpmSync, vfSync, ocSync})
    );

    // ****************************************
    // Register write decode
    // ****************************************
    assign wrPort = regReq.wr && regReq.addr == OFS_PORT_LINE_DATA;
    assign wrCtrl = regReq.wr && regReq.addr == OFS_TRANSCEIVER_CONTROL;
    assign wrIrqEn = regReq.wr && regReq.addr == OFS_FAULT_IRQ_ENABLE;
    assign wrFlags = regReq.wr && regReq.addr == OFS_FAULT_IRQ_FLAGS;

    // Port data: only the transmit override bit is writable
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            txOverride_r <= RST_TX_LINE_OVERRIDE;
        end else if (clkEn && wrPort) begin
            txOverride_r <= regReq.wrData[BIT_TX_LINE_OVERRIDE];
        end
    end

    // Control fields; enable can only be set, never cleared by software
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            enable_r <= 1'b0;
            bias_r <= 1'b0;
            wakeSel_r <= RST_WAKE_FILTER_SELECT;
            slewRateSelect <= RST_SLEW_RATE_SELECT;
        end else if (clkEn && wrCtrl) begin
            enable_r <= enable_r | regReq.wrData[BIT_TRANSCEIVER_ENABLE];
            bias_r <= regReq.wrData[BIT_MIDPOINT_BIAS_ENABLE];
            wakeSel_r <= regReq.wrData[POS_WAKE_FILTER_SELECT +: 2];
            // Reserved slew codes are dropped so the driver never sees them
            if (regReq.wrData[POS_SLEW_RATE_SELECT +: 3] != SLEW_RSVD_A &&
                regReq.wrData[POS_SLEW_RATE_SELECT +: 3] != SLEW_RSVD_B) begin
                slewRateSelect <= regReq.wrData[POS_SLEW_RATE_SELECT +: 3];
            end
        end
    end

    // Factory test bytes: writes outside special mode are silently ignored
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            factory_r[0] <= RST_FACTORY_TEST;
            factory_r[1] <= RST_FACTORY_TEST;
            factory_r[2] <= RST_FACTORY_TEST;
        end else if (clkEn && regReq.wr && specialMode) begin
            if (regReq.addr == OFS_FACTORY_TEST_A) begin
                factory_r[0] <= regReq.wrData;
            end
            if (regReq.addr == OFS_FACTORY_TEST_B) begin
                factory_r[1] <= regReq.wrData;
            end
            if (regReq.addr == OFS_FACTORY_TEST_C) begin
                factory_r[2] <= regReq.wrData;
            end
        end
    end

    // ****************************************
    // Transmit routing and dominant timeout
    // ****************************************
    // Low on the line input is dominant; override bit replaces controller
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            txLineIn <= 1'b1;
        end else if (clkEn) begin
            txLineIn <= txRouteToReg ? txOverride_r : controllerTxOut;
        end
    end

    assign dtEvent = !txLineIn && domCnt_r == TO_LAST;

    // Counter parks one past the event so a stuck line raises the flag only once
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            domCnt_r <= 16'h0000;
            recCnt_r <= 16'h0000;
            timeout_r <= 1'b0;
        end else if (clkEn) begin
            domCnt_r <= txLineIn ? 16'h0000 :
                        (domCnt_r == TO_CAP ? domCnt_r : domCnt_r + 16'h0001);
            recCnt_r <= (txLineIn && timeout_r) ? recCnt_r + 16'h0001 : 16'h0000;
            if (dtEvent) begin
                timeout_r <= 1'b1;
            end else if (txLineIn && recCnt_r == REC_LAST) begin
                timeout_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Mode and analog controls
    // ****************************************
    always_comb begin
        if (!enable_r) begin
            modeNxt = CTDC_SHUTDOWN;
        end else if (rpmSync) begin
            modeNxt = CTDC_STANDBY;
        end else begin
            modeNxt = CTDC_NORMAL;
        end
    end

    // Analog controls follow the mode in the same edge
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            transceiverMode <= CTDC_SHUTDOWN;
            wakeRxEnable <= 1'b0;
            midpointBiasDrive <= 1'b0;
        end else if (clkEn) begin
            transceiverMode <= modeNxt;
            wakeRxEnable <= modeNxt != CTDC_SHUTDOWN && wakeSel_r != WAKE_OFF;
            midpointBiasDrive <= bias_r && modeNxt == CTDC_NORMAL;
        end
    end

    // ****************************************
    // Wake pulse filter
    // ****************************************
    assign wakeFell = wakePrev_r && !wakeSync;
    assign maskHit = wakeFell && maskCnt_r != 2'h0;

    // Armed at stop entry; each masked event holds output recessive to its end
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            wakePrev_r <= 1'b1;
            stopPrev_r <= 1'b0;
            maskCnt_r <= 2'h0;
            suppress_r <= 1'b0;
        end else if (clkEn) begin
            wakePrev_r <= wakeSync;
            stopPrev_r <= cpuStopReq;
            if (cpuStopReq && !stopPrev_r) begin
                maskCnt_r <= wakeSel_r == WAKE_MASK_TWO ? 2'h2 :
                             (wakeSel_r == WAKE_MASK_ONE ? 2'h1 : 2'h0);
            end else if (maskHit && transceiverMode == CTDC_STANDBY) begin
                maskCnt_r <= maskCnt_r - 2'h1;
            end
            if (maskHit) begin
                suppress_r <= 1'b1;
            end else if (wakeSync) begin
                suppress_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Receive routing
    // ****************************************
    always_comb begin
        rxNxt = 1'b1;
        unique case (transceiverMode)
            CTDC_SHUTDOWN: rxNxt = 1'b1;
            CTDC_NORMAL: rxNxt = precSync;
            CTDC_STANDBY: rxNxt = (!wakeRxEnable || suppress_r || maskHit) ? 1'b1 : wakeSync;
        endcase
    end

    // Alternate routing parks the controller input recessive
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            rxLineOut <= 1'b1;
            controllerRxIn <= 1'b1;
        end else if (clkEn) begin
            rxLineOut <= rxNxt;
            controllerRxIn <= rxRouteAlt ? 1'b1 : rxNxt;
        end
    end

    // ****************************************
    // Fault flags
    // ****************************************
    assign irqSet = {vfSync ^ vfPrev_r, dtEvent, 1'b0, ocSync & ~ocPrev_r};
    assign irqClr = wrFlags ? (regReq.wrData & IRQ_FLAGS_MASK) : 8'h00;

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            vfPrev_r <= 4'h0;
            ocPrev_r <= 2'h0;
            irqFlags_r <= RST_IRQ;
            irqEnable_r <= RST_IRQ;
        end else if (clkEn) begin
            vfPrev_r <= vfSync;
            ocPrev_r <= ocSync;
            irqFlags_r <= (irqFlags_r & ~irqClr) | irqSet;
            if (wrIrqEn) begin
                irqEnable_r <= regReq.wrData & IRQ_ENABLE_MASK;
            end
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    always_comb begin
        rdValue = 8'h00;
        unique case (regReq.addr)
            OFS_PORT_LINE_DATA: rdValue = {wakeSync, 5'h00, txOverride_r, rxLineOut};
            OFS_TRANSCEIVER_CONTROL: rdValue = {enable_r, bias_r, wakeSel_r, 1'b0, slewRateSelect};
            OFS_FACTORY_TEST_A: rdValue = factory_r[0];
            OFS_LINE_MONITOR_STATUS: rdValue = {vfSync, timeout_r, 3'h0};
            OFS_FACTORY_TEST_B: rdValue = factory_r[1];
            OFS_FACTORY_TEST_C: rdValue = factory_r[2];
            OFS_FAULT_IRQ_ENABLE: rdValue = irqEnable_r;
            OFS_FAULT_IRQ_FLAGS: rdValue = irqFlags_r;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            regRdData <= regReq.rd ? rdValue : 8'h00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_tx_route;
        clkEn |=> txLineIn == ($past(txRouteToReg) ? $past(txOverride_r) : $past(controllerTxOut));
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("tx line routing wrong");

    property p_enable_once;
        enable_r |=> enable_r;
    endproperty
    a_enable_once: assert property (p_enable_once) else $error("enable cleared");

    property p_normal_rx;
        clkEn && transceiverMode == CTDC_NORMAL |=> rxLineOut == $past(precSync);
    endproperty
    a_normal_rx: assert property (p_normal_rx) else $error("rx not precision");

    property p_wake_off_shutdown;
        wakeRxEnable |-> transceiverMode != CTDC_SHUTDOWN && $past(wakeSel_r) != WAKE_OFF;
    endproperty
    a_wake_off_shutdown: assert property (p_wake_off_shutdown) else $error("wake on");

    property p_set_wins;
        clkEn && dtEvent |=> irqFlags_r[BIT_TX_DOMINANT_TIMEOUT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("timeout flag lost");

    property p_w1c;
        clkEn && wrFlags && regReq.wrData[0] && !irqSet[0] |=> !irqFlags_r[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");

    property p_factory_lock;
        clkEn && regReq.wr && regReq.addr == OFS_FACTORY_TEST_A && !specialMode
            |=> factory_r[0] == $past(factory_r[0]);
    endproperty
    a_factory_lock: assert property (p_factory_lock) else $error("factory write");

    property p_timeout_clear;
        $fell(timeout_r) |-> $past(recCnt_r) == REC_LAST && $past(txLineIn);
    endproperty
    a_timeout_clear: assert property (p_timeout_clear) else $error("early clear");

    property p_rd_rx;
        clkEn && regReq.rd && regReq.addr == OFS_PORT_LINE_DATA
            |=> regRdData[BIT_RX_LINE_SAMPLE] == $past(rxLineOut);
    endproperty
    a_rd_rx: assert property (p_rd_rx) else $error("rx sample wrong");

    property p_slew_legal;
        slewRateSelect != SLEW_RSVD_A && slewRateSelect != SLEW_RSVD_B;
    endproperty
    a_slew_legal: assert property (p_slew_legal) else $error("reserved slew");

endmodule : ctdc_top

/* File: verif/ctdc_ctrl_model.sv */
// Behavioural CAN protocol controller feeding the transceiver transmit input
module ctdc_ctrl_model (
    input wire logic clock,
    input wire logic dominantReq,
    output logic txOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic txOut_r = 1'b1;

    // Launches on the same clock as the real controller; idles recessive
    always @(posedge clock) begin
        txOut_r <= ~dominantReq;
    end
    assign txOut = txOut_r;
endmodule : ctdc_ctrl_model

/* File: verif/ctdc_top_tb.sv */
// Self-checking testbench for the CAN transceiver digital control block
module ctdc_top_tb;
    import ctdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // Short timeout keeps the dominant-timeout test quick
    localparam int TO_CYC = 20;
    localparam logic [7:0] RST_EXP [8] = '{8'h83, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    ctdc_bus_req_s regReq = '0;
    logic [7:0] regRdData;
    logic txRouteToReg = 1'b0, rxRouteAlt = 1'b0, specialMode = 1'b0, cpuStopReq = 1'b0;
    logic regulatorReducedPerformance = 1'b0, precisionRxLevel = 1'b1, wakeRxLevel = 1'b1;
    logic dominantReq = 1'b0;
    logic [3:0] voltageMonitor = 4'h0;
    logic [1:0] overCurrentMonitor = 2'h0;
    logic controllerTxOut, txLineIn, rxLineOut, controllerRxIn, midpointBiasDrive, wakeRxEnable;
    logic [2:0] slewRateSelect;
    logic [2:0] slewExp;
    logic sawLow;
    ctdc_mode_e transceiverMode;
    int errors = 0;
    int compares = 0;

    // ****************************************
    // Clock, design and partner
    // ****************************************
    always #20 clock = ~clock;

    ctdc_top #(.TIMEOUT_CYC(TO_CYC)) u_ctdc_top (.clock(clock), .rst_n(rst_n), .clkEn(1'b1),
        .regReq(regReq), .regRdData(regRdData), .controllerTxOut(controllerTxOut),
        .txRouteToReg(txRouteToReg), .rxRouteAlt(rxRouteAlt), .specialMode(specialMode),
        .cpuStopReq(cpuStopReq), .regulatorReducedPerformance(regulatorReducedPerformance),
        .precisionRxLevel(precisionRxLevel), .wakeRxLevel(wakeRxLevel),
        .voltageMonitor(voltageMonitor), .overCurrentMonitor(overCurrentMonitor),
        .txLineIn(txLineIn), .rxLineOut(rxLineOut),
        .controllerRxIn(controllerRxIn), .transceiverMode(transceiverMode),
        .midpointBiasDrive(midpointBiasDrive), .wakeRxEnable(wakeRxEnable),
        .slewRateSelect(slewRateSelect));

    ctdc_ctrl_model u_ctdc_ctrl_model (.clock(clock), .dominantReq(dominantReq),
        .txOut(controllerTxOut));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock) regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock) regReq <= '0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task rdchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock) regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock) regReq <= '0;
        #1 chk(regRdData, exp);
    endtask : rdchk

    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task finish_test;
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        finish_test();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        cyc(6);
        for (int i = 0; i < 8; i++) rdchk(3'(i), RST_EXP[i]);
        chk({6'h0, transceiverMode}, 8'(CTDC_SHUTDOWN));
        chk({7'h0, wakeRxEnable}, 8'h00);
        wr(OFS_TRANSCEIVER_CONTROL, 8'hD1);
        cyc(1);
        chk({6'h0, transceiverMode}, 8'(CTDC_NORMAL));
        chk({7'h0, midpointBiasDrive}, 8'h01);
        chk({7'h0, wakeRxEnable}, 8'h01);
        rdchk(OFS_TRANSCEIVER_CONTROL, 8'hD1);
        // Every slew code, with the enable bit written as zero each time
        slewExp = 3'h1;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_TRANSCEIVER_CONTROL, 8'(c));
            if (3'(c) != SLEW_RSVD_A && 3'(c) != SLEW_RSVD_B) slewExp = 3'(c);
            cyc(1);
            chk({5'h0, slewRateSelect}, {5'h0, slewExp});
            chk({6'h0, transceiverMode}, 8'(CTDC_NORMAL));
        end
        chk({7'h0, midpointBiasDrive}, 8'h00);
        for (int w = 0; w < 4; w++) begin
            wr(OFS_TRANSCEIVER_CONTROL, 8'(w << 4));
            cyc(1);
            chk({7'h0, wakeRxEnable}, {7'h0, w != 0});
        end
        // Receive path and its routing
        @(posedge clock) precisionRxLevel <= 1'b0;
        cyc(5);
        chk({6'h0, rxLineOut, controllerRxIn}, 8'h00);
        rdchk(OFS_PORT_LINE_DATA, 8'h82);
        @(posedge clock) rxRouteAlt <= 1'b1;
        cyc(2);
        chk({7'h0, controllerRxIn}, 8'h01);
        @(posedge clock) precisionRxLevel <= 1'b1;
        rxRouteAlt <= 1'b0;
        // Transmit path, brief dominant keeps clear of the timeout
        @(posedge clock) dominantReq <= 1'b1;
        cyc(3);
        chk({7'h0, txLineIn}, 8'h00);
        @(posedge clock) dominantReq <= 1'b0;
        cyc(3);
        chk({7'h0, txLineIn}, 8'h01);
        @(posedge clock) txRouteToReg <= 1'b1;
        wr(OFS_PORT_LINE_DATA, 8'h00);
        cyc(2);
        chk({7'h0, txLineIn}, 8'h00);
        cyc(TO_CYC + 4);
        rdchk(OFS_LINE_MONITOR_STATUS, 8'h08);
        rdchk(OFS_FAULT_IRQ_FLAGS, 8'h08);
        wr(OFS_FAULT_IRQ_FLAGS, 8'hF7);
        rdchk(OFS_FAULT_IRQ_FLAGS, 8'h08);
        wr(OFS_FAULT_IRQ_FLAGS, 8'h08);
        rdchk(OFS_FAULT_IRQ_FLAGS, 8'h00);
        wr(OFS_PORT_LINE_DATA, 8'h02);
        cyc(2);
        chk({7'h0, txLineIn}, 8'h01);
        cyc(12);
        rdchk(OFS_LINE_MONITOR_STATUS, 8'h08);
        cyc(20);
        rdchk(OFS_LINE_MONITOR_STATUS, 8'h00);
        // Factory test register only opens in special mode
        wr(OFS_FACTORY_TEST_A, 8'h5A);
        rdchk(OFS_FACTORY_TEST_A, 8'h00);
        @(posedge clock) specialMode <= 1'b1;
        wr(OFS_FACTORY_TEST_A, 8'h5A);
        rdchk(OFS_FACTORY_TEST_A, 8'h5A);
        // Enable bits outside the three sources read back as zero
        wr(OFS_FAULT_IRQ_ENABLE, 8'hFF);
        rdchk(OFS_FAULT_IRQ_ENABLE, 8'h19);
        // Monitor change and over-current rise raise flags that clear on a 1
        @(posedge clock) voltageMonitor <= 4'h8;
        overCurrentMonitor <= 2'h1;
        cyc(4);
        rdchk(OFS_LINE_MONITOR_STATUS, 8'h80);
        rdchk(OFS_FAULT_IRQ_FLAGS, 8'h81);
        wr(OFS_FAULT_IRQ_FLAGS, 8'h81);
        rdchk(OFS_FAULT_IRQ_FLAGS, 8'h00);
        // Standby with the first two wake pulses masked
        wr(OFS_TRANSCEIVER_CONTROL, 8'hB0);
        @(posedge clock) cpuStopReq <= 1'b1;
        @(posedge clock) regulatorReducedPerformance <= 1'b1;
        cyc(6);
        chk({6'h0, transceiverMode}, 8'(CTDC_STANDBY));
        chk({7'h0, wakeRxEnable}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            sawLow = 1'b0;
            @(posedge clock) wakeRxLevel <= 1'b0;
            repeat (6) begin
                @(posedge clock);
                #1 if (rxLineOut === 1'b0) sawLow = 1'b1;
            end
            wakeRxLevel <= 1'b1;
            repeat (6) @(posedge clock);
            chk({7'h0, sawLow}, {7'h0, i == 2});
        end
        finish_test();
    end
endmodule : ctdc_top_tb
